// *** core/pin_sync.sv ***
// Purpose: two-flop synchroniser for one asynchronous pin
// Assumes: single clock, synchronous active-high reset
// Notes: first stage feeds only the second
`timescale 1ns/1ps
`default_nettype none

module pin_sync (
  input wire logic clock,
  input wire logic rst,
  input wire logic pinIn,
  output logic syncOut
);
  logic stage1;
  logic next_stage1;
  logic next_syncOut;

  // ==========================================
  // Next values
  always_comb begin
    next_stage1 = pinIn;
    next_syncOut = stage1;
  end

  // Two flops in a row
  always_ff @(posedge clock) begin
    if (rst) begin
      stage1 <= 1'b0;
      syncOut <= 1'b0;
    end else begin
      stage1 <= next_stage1;
      syncOut <= next_syncOut;
    end
  end
endmodule : pin_sync

`default_nettype wire

// *** core/rx_framer_clock_select.sv ***
// Purpose: receive character framer and receive clock source selection
// Assumes: rawWord holds ten unaligned bits per rawValid pulse
// Notes: registers over AHB-Lite, zero wait states
`timescale 1ns/1ps
`default_nettype none

module rx_framer_clock_select
  import rx_framer_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic referenceClockIn,
  input wire logic reframePermit,
  input wire logic [9:0] rawWord,
  input wire logic rawValid,
  output logic [9:0] rxData,
  output logic [2:0] rxCharStatus,
  output logic rxDataValid,
  output clk_pair_s rxCharClockPair,
  output logic delayedRefClockOut,
  output logic delayedRefClockOe
);
  // ==========================================
  // Declarations
  ctrl_s ctrl;
  ctrl_s next_ctrl;
  logic wrPend;
  logic next_wrPend;
  logic [31:0] wrAddr;
  logic [31:0] next_wrAddr;
  logic [31:0] next_hrdata;
  logic [31:0] statusWord;
  logic addrPhase;
  logic permitSync;
  logic refSync;
  logic [9:0] prevWord;
  logic [9:0] next_prevWord;
  logic [18:0] window;
  logic [9:0] hits;
  logic hitAny;
  logic [3:0] hitOff;
  frame_state_e state;
  frame_state_e next_state;
  logic [3:0] offset;
  logic [3:0] next_offset;
  logic [3:0] cand;
  logic [3:0] next_cand;
  logic [2:0] candCnt;
  logic [2:0] next_candCnt;
  logic [1:0] stretchCnt;
  logic [1:0] next_stretchCnt;
  logic [7:0] realignCnt;
  logic [7:0] next_realignCnt;
  logic realigned;
  logic next_realigned;
  logic [9:0] next_rxData;
  logic [2:0] next_rxCharStatus;
  logic next_rxDataValid;
  logic clkTick;
  logic next_clkTick;
  logic recTrue;
  logic next_recTrue;
  logic [1:0] highCnt;
  logic [1:0] next_highCnt;
  logic refDly;
  logic next_refDly;
  clk_pair_s next_pair;
  logic next_delayedOut;
  logic next_delayedOe;
  // ==========================================
  // Pin synchronisers
  pin_sync u_permitSync (.clock(clock), .rst(rst), .pinIn(reframePermit),
    .syncOut(permitSync));
  pin_sync u_refSync (.clock(clock), .rst(rst), .pinIn(referenceClockIn),
    .syncOut(refSync));
  // ==========================================
  // AHB-Lite register slave
  assign addrPhase = hsel && htrans[1] && hready;
  // Status word read by software
  always_comb begin
    statusWord = 32'h0000_0000;
    statusWord[`STATUS_OFFSET_LSB +: 4] = offset;
    statusWord[`STATUS_PERMIT_BIT] = permitSync;
    statusWord[`STATUS_LOCKED_BIT] = (state == ST_TRACK);
    statusWord[`STATUS_PENDING_BIT] = (state == ST_CONFIRM);
    statusWord[`STATUS_COUNT_LSB +: 8] = realignCnt;
  end
  // Address phase capture, data phase write, early read data
  always_comb begin
    next_ctrl = ctrl;
    next_wrPend = 1'b0;
    next_wrAddr = wrAddr;
    next_hrdata = hrdata;
    if (wrPend && (wrAddr == `ADDR_CTRL)) begin
      next_ctrl = ctrl_s'(hwdata[`CTRL_WIDTH-1:0]);
    end
    if (addrPhase) begin
      next_wrPend = hwrite;
      next_wrAddr = haddr;
      if (hwrite) begin
        next_hrdata = 32'h0000_0000;
      end else if (haddr == `ADDR_CTRL) begin
        next_hrdata = {21'h000000, ctrl};
      end else if (haddr == `ADDR_STATUS) begin
        next_hrdata = statusWord;
      end else begin
        next_hrdata = 32'h0000_0000;
      end
    end
  end
  // Bus registers, slave never stalls and always answers OKAY
  always_ff @(posedge clock) begin
    hreadyout <= 1'b1;
    hresp <= 1'b0;
    if (rst) begin
      ctrl <= ctrl_s'(`CTRL_RESET);
      wrPend <= 1'b0;
      wrAddr <= 32'h0000_0000;
      hrdata <= 32'h0000_0000;
    end else begin
      ctrl <= next_ctrl;
      wrPend <= next_wrPend;
      wrAddr <= next_wrAddr;
      hrdata <= next_hrdata;
    end
  end

  // ==========================================
  // Symbol search over two received words
  assign window = {rawWord[8:0], prevWord};
  // Symbol low finds nothing, kept for component test
  symbol_detect u_detect (.window(window), .symbolSel(ctrl.framingSymbolSel),
    .hits(hits));
  // Lowest matching offset wins
  always_comb begin
    hitAny = 1'b0;
    hitOff = 4'h0;
    for (int i = `CHAR_BITS - 1; i >= 0; i--) begin
      if (hits[i]) begin
        hitAny = 1'b1;
        hitOff = 4'(i);
      end
    end
  end

  // ==========================================
  // Framer state machine
  always_comb begin
    next_state = state;
    next_offset = offset;
    next_cand = cand;
    next_candCnt = candCnt;
    next_stretchCnt = stretchCnt;
    next_realignCnt = realignCnt;
    next_realigned = realigned && !rawValid; // Held until the next character reports it
    next_prevWord = prevWord;
    if (rawValid) begin
      next_prevWord = rawWord;
      case (state)
        ST_TRACK: begin
          if (permitSync && hitAny && (hitOff != offset)) begin
            if (ctrl.reframingMethodSel == LVL_LOW) begin
              next_offset = hitOff;
              next_stretchCnt = `STRETCH_CHARS;
              next_realignCnt = realignCnt + 8'h01;
              next_realigned = 1'b1;
              next_state = ST_STRETCH;
            end else begin
              next_cand = hitOff;
              next_candCnt = 3'h1;
              next_state = ST_CONFIRM;
            end
          end
        end
        ST_CONFIRM: begin
          if (!permitSync) begin
            next_state = ST_TRACK;
          end else if (ctrl.reframingMethodSel == LVL_MID) begin
            if (hits[cand]) begin
              next_offset = cand;
              next_realignCnt = realignCnt + 8'h01;
              next_realigned = 1'b1;
              next_state = ST_TRACK;
            end else if (candCnt >= `MULTI_WINDOW_CHARS - 3'h1) begin
              next_state = ST_TRACK;
            end else begin
              next_candCnt = candCnt + 3'h1;
            end
          end else begin
            if (!hits[cand]) begin
              next_state = ST_TRACK;
            end else if (candCnt + 3'h1 >= `ADJACENT_CHARS) begin
              next_offset = cand;
              next_realignCnt = realignCnt + 8'h01;
              next_realigned = 1'b1;
              next_state = ST_TRACK;
            end else begin
              next_candCnt = candCnt + 3'h1;
            end
          end
        end
        ST_STRETCH: begin
          if (stretchCnt <= 2'h1) begin
            next_stretchCnt = 2'h0;
            next_state = ST_TRACK;
          end else begin
            next_stretchCnt = stretchCnt - 2'h1;
          end
        end
        default: begin
          next_state = ST_TRACK;
        end
      endcase
    end
  end
  // Framer registers
  always_ff @(posedge clock) begin
    if (rst) begin
      state <= ST_TRACK;
      offset <= 4'h0;
      cand <= 4'h0;
      candCnt <= 3'h0;
      stretchCnt <= 2'h0;
      realignCnt <= 8'h00;
      realigned <= 1'b0;
      prevWord <= 10'h000;
    end else begin
      state <= next_state;
      offset <= next_offset;
      cand <= next_cand;
      candCnt <= next_candCnt;
      stretchCnt <= next_stretchCnt;
      realignCnt <= next_realignCnt;
      realigned <= next_realigned;
      prevWord <= next_prevWord;
    end
  end

  // ==========================================
  // Aligned character and status
  always_comb begin
    next_rxData = rxData;
    next_rxCharStatus = rxCharStatus;
    next_rxDataValid = rawValid;
    if (rawValid) begin
      next_rxData = window[offset +: 10];
      if (ctrl.decoderModeSel == LVL_LOW) begin
        next_rxCharStatus = {hits[offset], 2'b00};
      end else if (ctrl.statusReportSel == LVL_LOW) begin
        next_rxCharStatus = {state == ST_TRACK, realigned, hits[offset]};
      end else begin
        next_rxCharStatus = {state == ST_CONFIRM, permitSync, hits[offset]};
      end
    end
  end
  // Output data registers
  always_ff @(posedge clock) begin
    if (rst) begin
      rxData <= 10'h000;
      rxCharStatus <= 3'h0;
      rxDataValid <= 1'b0;
    end else begin
      rxData <= next_rxData;
      rxCharStatus <= next_rxCharStatus;
      rxDataValid <= next_rxDataValid;
    end
  end

  // ==========================================
  // Clock pair and delayed reference output
  always_comb begin
    next_clkTick = rawValid && (state != ST_STRETCH);
    next_recTrue = recTrue;
    next_highCnt = highCnt;
    next_refDly = refSync;
    next_pair = rxCharClockPair;
    next_delayedOut = 1'b0;
    next_delayedOe = 1'b0;
    // Edge follows data by two cycles so the host sees stable data
    if (!ctrl.rateHalf) begin
      if (clkTick) begin
        next_recTrue = 1'b1;
        next_highCnt = `RX_CHAR_CLOCK_PAIR_HIGH_CYCLES;
      end else if (highCnt > 2'h1) begin
        next_highCnt = highCnt - 2'h1;
      end else begin
        next_highCnt = 2'h0;
        next_recTrue = 1'b0;
      end
    end else begin
      next_highCnt = 2'h0;
      if (clkTick) begin
        next_recTrue = !recTrue;
      end
    end
    if (ctrl.clockSourceSel == LVL_LOW) begin
      next_pair.trueClk = refSync;
      next_pair.compClk = !refSync;
      next_pair.oe = 1'b1;
      next_delayedOut = refDly;
      next_delayedOe = 1'b1;
    end else if (ctrl.clockSourceSel == LVL_MID) begin
      next_pair.trueClk = recTrue;
      next_pair.compClk = !recTrue;
      next_pair.oe = 1'b1;
    end else begin
      next_pair.trueClk = 1'b0;
      next_pair.compClk = 1'b0;
      next_pair.oe = 1'b0;
    end
  end
  // Clock registers
  always_ff @(posedge clock) begin
    if (rst) begin
      clkTick <= 1'b0;
      recTrue <= 1'b0;
      highCnt <= 2'h0;
      refDly <= 1'b0;
      rxCharClockPair <= '0;
      delayedRefClockOut <= 1'b0;
      delayedRefClockOe <= 1'b0;
    end else begin
      clkTick <= next_clkTick;
      recTrue <= next_recTrue;
      highCnt <= next_highCnt;
      refDly <= next_refDly;
      rxCharClockPair <= next_pair;
      delayedRefClockOut <= next_delayedOut;
      delayedRefClockOe <= next_delayedOe;
    end
  end
endmodule : rx_framer_clock_select

`default_nettype wire

// *** core/rx_framer_consts.svh ***
// Purpose: constants of the receive framer and clock select block
// Assumes: included by its bare name inside the package
// Notes: definitions only
`ifndef RX_FRAMER_CONSTS_SVH
`define RX_FRAMER_CONSTS_SVH

// ==========================================
// Register map
`define ADDR_CTRL 32'h0000_0000
`define ADDR_STATUS 32'h0000_0004
`define CTRL_WIDTH 11
`define CTRL_RESET 11'h052
`define STATUS_OFFSET_LSB 0
`define STATUS_PERMIT_BIT 4
`define STATUS_LOCKED_BIT 5
`define STATUS_PENDING_BIT 6
`define STATUS_COUNT_LSB 8

// ==========================================
// Framing symbols, lowest bit received first
`define COMMA_NEG 7'h7C
`define COMMA_POS 7'h03
`define K285_NEG 10'h17C
`define K285_POS 10'h283

// ==========================================
// Framing and clock timing
`define CHAR_BITS 10
`define MULTI_WINDOW_CHARS 3'd5
`define ADJACENT_CHARS 3'd4
`define STRETCH_CHARS 2'd1
`define RX_CHAR_CLOCK_PAIR_HIGH_CYCLES 2'd2

`endif

// *** core/rx_framer_pkg.sv ***
// Purpose: types shared by the receive framer files
// Assumes: constants come from the guarded header
// Notes: three-level pins are two-bit codes
package rx_framer_pkg;
  `include "rx_framer_consts.svh"

  // ==========================================
  // Three-level static selects
  typedef enum logic [1:0] {
    LVL_LOW = 2'b00,
    LVL_MID = 2'b01,
    LVL_HIGH = 2'b10,
    LVL_BAD = 2'b11
  } level_e;

  // Framer states, Gray coded
  typedef enum logic [1:0] {
    ST_TRACK = 2'b00,
    ST_CONFIRM = 2'b01,
    ST_STRETCH = 2'b10
  } frame_state_e;

  // Control word, field order fixes the bit layout
  typedef struct packed {
    logic rateHalf;
    level_e statusReportSel;
    level_e decoderModeSel;
    level_e clockSourceSel;
    level_e reframingMethodSel;
    level_e framingSymbolSel;
  } ctrl_s;

  // Three-state clock pair pins
  typedef struct packed {
    logic trueClk;
    logic compClk;
    logic oe;
  } clk_pair_s;
endpackage : rx_framer_pkg

// *** core/symbol_detect.sv ***
// Purpose: framing symbol search at all ten bit offsets
// Assumes: window bit 0 is the oldest received bit
// Notes: purely combinational
`timescale 1ns/1ps
`default_nettype none

module symbol_detect
  import rx_framer_pkg::*;
(
  input wire logic [18:0] window,
  input wire level_e symbolSel,
  output logic [9:0] hits
);
  // ==========================================
  // One comparator pair per offset
  genvar k;
  generate
    for (k = 0; k < `CHAR_BITS; k++) begin : g_off
      logic [9:0] slice;
      assign slice = window[k +: 10];
      always_comb begin
        if (symbolSel == LVL_MID) begin
          hits[k] = (slice[6:0] == `COMMA_NEG) || (slice[6:0] == `COMMA_POS);
        end else if (symbolSel == LVL_HIGH) begin
          hits[k] = (slice == `K285_NEG) || (slice == `K285_POS);
        end else begin
          hits[k] = 1'b0;
        end
      end
    end
  endgenerate
endmodule : symbol_detect

`default_nettype wire

// *** tb/host_capture.sv ***
// Purpose: host logic latching receive characters on the pair clock
// Assumes: pair clock sampled with the system clock
// Notes: counts every capture made
`timescale 1ns/1ps
`default_nettype none

module host_capture
  import rx_framer_pkg::*;
(
  input wire logic clock,
  input wire clk_pair_s pair,
  input wire logic [9:0] rxData,
  input wire logic halfRate,
  output logic [9:0] lastChar,
  output int captures
);
  // ==========================================
  // Capture edges
  logic trueSeen = 1'b0;
  initial captures = 0;
  // True rise always, complement rise only at half rate
  always @(posedge clock) begin
    trueSeen <= pair.trueClk;
    if (pair.oe && pair.trueClk && !trueSeen
        || pair.oe && halfRate && !pair.trueClk && trueSeen) begin
      lastChar <= rxData;
      captures <= captures + 1;
    end
  end
endmodule : host_capture
`default_nettype wire

// *** tb/rx_framer_checker_assertions.sv ***
// Purpose: port assertions of the receive framer and clock select
// Assumes: bound to the top module, single clock
// Notes: mode-change guards skip the pipeline depth
`timescale 1ns/1ps
`default_nettype none

module rx_framer_checker
  import rx_framer_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic referenceClockIn,
  input wire logic rawValid,
  input wire logic [9:0] rxData,
  input wire logic rxDataValid,
  input wire clk_pair_s rxCharClockPair,
  input wire logic delayedRefClockOut,
  input wire logic delayedRefClockOe
);
  // ==========================================
  // Clock outputs and character stream
  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  property p_ref_out;
    delayedRefClockOe && $past(delayedRefClockOe, 4) |->
      delayedRefClockOut == $past(referenceClockIn, 4);
  endproperty
  a_ref_out: assert property (p_ref_out) else $error("delayed copy wrong");
  property p_ref_pair;
    delayedRefClockOe && $past(delayedRefClockOe, 3) |-> rxCharClockPair.oe &&
      rxCharClockPair.trueClk == $past(referenceClockIn, 3);
  endproperty
  a_ref_pair: assert property (p_ref_pair) else $error("pair not following ref");
  property p_comp;
    rxCharClockPair.oe |-> rxCharClockPair.compClk != rxCharClockPair.trueClk;
  endproperty
  a_comp: assert property (p_comp) else $error("pair not complementary");
  property p_pulse;
    rawValid |=> rxDataValid ##1 !rxDataValid;
  endproperty
  a_pulse: assert property (p_pulse) else $error("valid pulse wrong");
  property p_cause;
    rxDataValid |-> $past(rawValid);
  endproperty
  a_cause: assert property (p_cause) else $error("valid without character");
  property p_hold;
    !rxDataValid |-> $stable(rxData);
  endproperty
  a_hold: assert property (p_hold) else $error("data moved between characters");
  property p_tick;
    $rose(rxCharClockPair.trueClk) && rxCharClockPair.oe && !delayedRefClockOe &&
      !$past(delayedRefClockOe, 4) |-> $past(rxDataValid, 2);
  endproperty
  a_tick: assert property (p_tick) else $error("pair tick without character");
  property p_high;
    $rose(rxCharClockPair.trueClk) && rxCharClockPair.oe && !delayedRefClockOe |=>
      rxCharClockPair.trueClk;
  endproperty
  a_high: assert property (p_high) else $error("pair high phase too short");
endmodule : rx_framer_checker

// ==========================================
// Attach to the top module
bind rx_framer_clock_select rx_framer_checker rx_framer_checker_inst (
  .clock(clock), .rst(rst), .referenceClockIn(referenceClockIn), .rawValid(rawValid),
  .rxData(rxData), .rxDataValid(rxDataValid), .rxCharClockPair(rxCharClockPair),
  .delayedRefClockOut(delayedRefClockOut), .delayedRefClockOe(delayedRefClockOe)
);
`default_nettype wire

// *** tb/testbench.sv ***
// Purpose: self-checking bench of the receive framer and clock select
// Assumes: zero-wait bus slave, characters five cycles apart
// Notes: received stream is a bit vector, oldest bit lowest
`timescale 1ns/1ps
`default_nettype none
`include "rx_framer_consts.svh"

module testbench
  import rx_framer_pkg::*;
();
  // ==========================================
  // Signals
  localparam logic [9:0] FillChar = 10'h0B5;
  logic clock = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000;
  logic [1:0] htrans = 2'b00;
  logic [2:0] hsize = 3'b010;
  logic referenceClockIn = 1'b0, reframePermit = 1'b1, rawValid = 1'b0, halfRate = 1'b0;
  logic [9:0] rawWord = 10'h000;
  logic hreadyout, hresp, rxDataValid, delayedRefClockOut, delayedRefClockOe;
  logic [31:0] hrdata;
  logic [9:0] rxData, lastChar;
  logic [2:0] rxCharStatus;
  clk_pair_s rxCharClockPair;
  logic [99:0] bitStream;
  logic [7:0] cnt = 8'h00;
  logic [3:0] off = 4'h0;
  int captures, t0, fail_count = 0, tests_run = 0;

  // Clocks, reference at six cycles a period
  always #12.5 clock = ~clock;
  always begin
    repeat (3) @(posedge clock);
    referenceClockIn <= ~referenceClockIn;
  end

  rx_framer_clock_select rx_framer_clock_select_inst (
    .clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .referenceClockIn(referenceClockIn), .reframePermit(reframePermit), .rawWord(rawWord),
    .rawValid(rawValid), .rxData(rxData), .rxCharStatus(rxCharStatus),
    .rxDataValid(rxDataValid), .rxCharClockPair(rxCharClockPair),
    .delayedRefClockOut(delayedRefClockOut), .delayedRefClockOe(delayedRefClockOe)
  );
  host_capture host_capture_inst (
    .clock(clock), .pair(rxCharClockPair), .rxData(rxData), .halfRate(halfRate),
    .lastChar(lastChar), .captures(captures)
  );

  // ==========================================
  // Tasks
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Single bus transfer, read data compared with d
  task automatic xfer(input logic wr, input logic [31:0] a, d, input string what);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= wr;
    do @(posedge clock); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'b1);
    if (!wr) chk(what, d, hrdata);
  endtask : xfer

  // Filler stream with ns symbols on adjacent characters at offset k
  task automatic build(input int k, input int ns, input logic [9:0] s);
    bitStream = {10{FillChar}};
    for (int c = 0; c < ns; c++) bitStream[20 + 10 * c + k +: 10] = s;
  endtask : build

  task automatic send(input int n);
    for (int w = 0; w < n; w++) begin
      rawWord <= bitStream[10 * w +: 10];
      rawValid <= 1'b1;
      @(posedge clock);
      rawValid <= 1'b0;
      repeat (4) @(posedge clock);
    end
    repeat (4) @(posedge clock);
  endtask : send

  task automatic trial(input logic [10:0] ctrl, input int k, ns, input logic [9:0] s,
      input logic mv);
    xfer(1'b1, `ADDR_CTRL, {21'h0, ctrl}, "");
    build(k, ns, s);
    t0 = captures;
    send(9);
    if (mv) begin
      off = 4'(k);
      cnt++;
    end
    chk("aligned char", {22'h0, bitStream[70 + off +: 10]}, {22'h0, rxData});
    chk("pair ticks", 32'(t0 + 9 - int'(mv && ctrl[3:2] == 2'b00)), 32'(captures));
    xfer(1'b0, `ADDR_STATUS, {16'h0, cnt, 3'b001, reframePermit, off}, "status");
  endtask : trial

  task automatic conclude();
    $display("Checks %0d, errors %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : conclude

  // ==========================================
  // Main sequence
  initial begin
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    xfer(1'b0, `ADDR_CTRL, 32'h0000_0052, "ctrl reset");
    xfer(1'b0, 32'h0000_0008, 32'h0000_0000, "unmapped");
    xfer(1'b0, `ADDR_STATUS, 32'h0000_0030, "status reset");
    xfer(1'b1, `ADDR_CTRL, 32'hFFFF_FFFF, "");
    xfer(1'b0, `ADDR_CTRL, 32'h0000_07FF, "ctrl mask");
    trial(11'h052, 3, 1, `K285_NEG, 1'b1);
    trial(11'h051, 7, 1, `K285_POS, 1'b1);
    trial(11'h056, 2, 1, `K285_NEG, 1'b0);
    trial(11'h056, 2, 2, `K285_NEG, 1'b1);
    trial(11'h05A, 9, 3, `K285_POS, 1'b0);
    trial(11'h05A, 9, 4, `K285_POS, 1'b1);
    reframePermit <= 1'b0;
    trial(11'h052, 4, 1, `K285_NEG, 1'b0);
    reframePermit <= 1'b1;
    build(0, 0, 10'h000);
    // Status report modes, ignored with the decoder bypassed
    for (int d = 0; d < 2; d++) begin
      for (int r = 0; r < 2; r++) begin
        xfer(1'b1, `ADDR_CTRL, 32'h0000_0012 | 32'(d << 6) | 32'(r << 8), "");
        send(1);
        chk("char status", d == 0 ? 32'h0 : (r == 0 ? 32'h4 : 32'h2), 32'(rxCharStatus));
      end
    end
    halfRate <= 1'b1;
    xfer(1'b1, `ADDR_CTRL, 32'h0000_0452, "");
    t0 = captures;
    send(8);
    chk("half rate captures", 32'h0000_0008, 32'(captures - t0));
    chk("half rate char", {22'h0, bitStream[60 + off +: 10]}, {22'h0, lastChar});
    halfRate <= 1'b0;
    // Source select: reference, recovered, disabled
    for (int s = 0; s < 3; s++) begin
      xfer(1'b1, `ADDR_CTRL, 32'h0000_0442 | 32'(s << 4), "");
      repeat (12) @(posedge clock);
      chk("clock enables", 32'(s == 0) << 1 | 32'(s < 2),
        {30'h0, delayedRefClockOe, rxCharClockPair.oe});
    end
    conclude();
  end

  // Watchdog, far beyond the expected run length
  initial begin
    repeat (20000) @(posedge clock);
    fail_count++;
    conclude();
  end
endmodule : testbench
`default_nettype wire
